// ===== hw/usse_cfg.svh
`ifndef USSE_CFG_SVH
`define USSE_CFG_SVH

// ****************************************
// register map, byte addresses
// ****************************************
`define USSE_ADDR_CTRL 8'h00
`define USSE_ADDR_BUF 8'h04
`define USSE_ADDR_CFG 8'h08
`define USSE_ADDR_STAT 8'h0c

// ****************************************
// field positions
// ****************************************
`define USSE_CTRL_MODE_HI 7
`define USSE_CTRL_MODE_LO 6
`define USSE_CTRL_MPC 5
`define USSE_CTRL_REN 4
`define USSE_CTRL_TX9 3
`define USSE_CTRL_RX9 2
`define USSE_CTRL_TXDONE 1
`define USSE_CTRL_RXDONE 0
`define USSE_CFG_BAUD_DBL 0
`define USSE_STAT_TXACT 0
`define USSE_STAT_RXACT 1

// ****************************************
// reset values
// ****************************************
`define USSE_CTRL_RST 8'h00
`define USSE_CFG_RST 1'b0
`define USSE_BUF_RST 8'h00

// ****************************************
// timing counts and shift patterns
// ****************************************
`define USSE_MC_LEN 12
`define USSE_SCK_LO_FIRST 4'h3
`define USSE_SCK_LO_LAST 4'h8
`define USSE_SCK_SAMPLE 4'h9
`define USSE_DIV_LAST 4'hf
`define USSE_VOTE_FIRST 4'h6
`define USSE_VOTE_LAST 4'h8
`define USSE_VOTE_DECIDE 4'h9
`define USSE_VOTES 3
`define USSE_OVF_LAST_DBL 2'h1
`define USSE_OVF_LAST_NORM 2'h3
`define USSE_TX_MARK 1'b1
`define USSE_TX_END 8'h01
`define USSE_RX0_INIT 9'h1fe
`define USSE_RX1_INIT 9'h1ff
`define USSE_RESP_OKAY 2'b00
`define USSE_RESP_SLVERR 2'b10

`endif

// ===== hw/usse_pkg.sv
package usse_pkg;

	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_ASYNC8 = 2'b01,
		MODE_FIX9 = 2'b10,
		MODE_VAR9 = 2'b11
	} usse_mode_t;

	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_WAIT = 5'b00010,
		TX_ALIGN = 5'b00100,
		TX_START = 5'b01000,
		TX_SHIFT = 5'b10000
	} usse_tx_st_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_SYNC = 4'b0010,
		RX_START = 4'b0100,
		RX_BITS = 4'b1000
	} usse_rx_st_t;

	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic wlane;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} usse_axi_t;

	typedef struct packed {
		usse_axi_t axi;
		logic [7:0] ctrl;
		logic baud_dbl;
		logic [7:0] serial_buffer;
		usse_tx_st_t tx_st;
		logic [8:0] tsr;
		logic [3:0] tx_div;
		usse_rx_st_t rx_st;
		logic [8:0] rsr;
		logic [3:0] rx_div;
		logic rx_prev;
		logic txd;
		logic rxd_out;
		logic rxd_oe;
	} usse_state_t;

	typedef struct packed {
		logic [3:0] phase;
		logic [1:0] ovf;
	} usse_tick_t;

endpackage : usse_pkg

// ===== hw/usse_tick.sv
`timescale 1ns/10ps
`include "usse_cfg.svh"
module usse_tick import usse_pkg::*; #(
	parameter int MC_LEN = `USSE_MC_LEN
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// rate sources
	input wire logic timer_ovf,
	input wire logic baud_dbl,
	// ticks
	output logic [3:0] mc_phase,
	output logic mc_tick,
	output logic baud_tick
);
	localparam logic [3:0] MC_LAST = 4'(MC_LEN - 1);

	// the shift clock waveform needs phases up to the sample point
	if (MC_LEN < 10 || MC_LEN > 16) begin : g_bad_len
		$error("usse_tick: MC_LEN must be 10..16");
	end

	usse_tick_t q, d;

	assign mc_phase = q.phase;
	assign mc_tick = q.phase == MC_LAST;
	// overflow divided by 2 or 4 gives sixteen ticks per bit
	assign baud_tick = timer_ovf && (q.ovf == (baud_dbl ? `USSE_OVF_LAST_DBL : `USSE_OVF_LAST_NORM));

	always_comb begin
		d = q;
		d.phase = mc_tick ? 4'h0 : 4'(q.phase + 4'h1);
		if (timer_ovf) begin
			d.ovf = baud_tick ? 2'h0 : 2'(q.ovf + 2'h1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end
endmodule : usse_tick

// ===== hw/usse_vote.sv
`timescale 1ns/10ps
module usse_vote #(
	parameter int N = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// samples
	input wire logic clr,
	input wire logic smp_en,
	input wire logic din,
	// majority of the last N samples
	output logic maj
);
	if (N < 3 || (N % 2) == 0) begin : g_bad_n
		$error("usse_vote: N must be odd and at least 3");
	end

	logic [N-1:0] q, d;
	int ones;

	always_comb begin
		ones = 0;
		for (int i = 0; i < N; i++) begin
			ones = ones + int'(q[i]);
		end
		maj = ones > (N / 2);
		d = q;
		if (clr) begin
			d = '0;
		end else if (smp_en) begin
			d = {q[N-2:0], din};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end
endmodule : usse_vote

// ===== hw/usse_top.sv
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "usse_cfg.svh"
module usse_top import usse_pkg::*; #(
	parameter int MC_LEN = `USSE_MC_LEN
) (
	// clock, reset, enable
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// axi4-lite write channels
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read channels
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// baud source
	input wire logic TIMER_OVF,
	// serial pins
	input wire logic RXD_IN,
	output logic RXD_OUT,
	output logic RXD_OE,
	output logic TXD_OUT
);
	// ****************************************
	// timing sources
	// ****************************************
	usse_state_t q, d;
	logic [3:0] mc_phase;
	logic mc_tick;
	logic btick;
	logic vote_clr;
	logic vote_en;
	logic vote_bit;

	usse_tick #(
		.MC_LEN(MC_LEN)
	) u_tick (
		.clk(MCLK),
		.rst_n(RESET_N),
		.ce(CLK_EN),
		.timer_ovf(TIMER_OVF),
		.baud_dbl(q.baud_dbl),
		.mc_phase(mc_phase),
		.mc_tick(mc_tick),
		.baud_tick(btick)
	);

	usse_vote #(
		.N(`USSE_VOTES)
	) u_vote (
		.clk(MCLK),
		.rst_n(RESET_N),
		.ce(CLK_EN),
		.clr(vote_clr),
		.smp_en(vote_en),
		.din(RXD_IN),
		.maj(vote_bit)
	);

	function automatic logic [7:0] usse_rev8(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction : usse_rev8

	// ****************************************
	// next-state logic
	// ****************************************
	usse_mode_t mode;
	logic aw_take, w_take, ar_take, do_wr;
	logic [7:0] wa, wd;
	logic wl, wr_ctrl, wr_buf, wr_cfg, wr_ok;
	logic tx_roll, tx_shift_ev, rx_decide;
	logic tx_set, rx_set, rx9_set, rx9_val;
	logic sync_act;

	assign mode = usse_mode_t'({q.ctrl[`USSE_CTRL_MODE_HI], q.ctrl[`USSE_CTRL_MODE_LO]});
	assign tx_roll = btick && (q.tx_div == `USSE_DIV_LAST);
	assign rx_decide = btick && (q.rx_div == `USSE_VOTE_DECIDE);
	assign vote_en = btick && (q.rx_st == RX_START || q.rx_st == RX_BITS)
		&& q.rx_div >= `USSE_VOTE_FIRST && q.rx_div <= `USSE_VOTE_LAST;

	always_comb begin
		d = q;
		tx_set = 1'b0;
		rx_set = 1'b0;
		rx9_set = 1'b0;
		rx9_val = 1'b0;
		vote_clr = 1'b0;
		tx_shift_ev = 1'b0;

		// ---- write channels: address and data in either order
		aw_take = S_AXI_AWVALID && q.axi.awrdy;
		w_take = S_AXI_WVALID && q.axi.wrdy;
		wa = aw_take ? S_AXI_AWADDR : q.axi.waddr;
		wd = w_take ? S_AXI_WDATA[7:0] : q.axi.wdata;
		wl = w_take ? S_AXI_WSTRB[0] : q.axi.wlane;
		do_wr = (aw_take || q.axi.aw_got) && (w_take || q.axi.w_got);
		wr_ok = wa == `USSE_ADDR_CTRL || wa == `USSE_ADDR_BUF
			|| wa == `USSE_ADDR_CFG || wa == `USSE_ADDR_STAT;
		wr_ctrl = do_wr && wl && wa == `USSE_ADDR_CTRL;
		wr_buf = do_wr && wl && wa == `USSE_ADDR_BUF;
		wr_cfg = do_wr && wl && wa == `USSE_ADDR_CFG;
		if (q.axi.bvalid && S_AXI_BREADY) begin
			d.axi.bvalid = 1'b0;
			d.axi.awrdy = 1'b1;
			d.axi.wrdy = 1'b1;
		end
		if (aw_take) begin
			d.axi.awrdy = 1'b0;
			d.axi.aw_got = 1'b1;
			d.axi.waddr = S_AXI_AWADDR;
		end
		if (w_take) begin
			d.axi.wrdy = 1'b0;
			d.axi.w_got = 1'b1;
			d.axi.wdata = S_AXI_WDATA[7:0];
			d.axi.wlane = S_AXI_WSTRB[0];
		end
		if (do_wr) begin
			d.axi.aw_got = 1'b0;
			d.axi.w_got = 1'b0;
			d.axi.bvalid = 1'b1;
			d.axi.bresp = wr_ok ? `USSE_RESP_OKAY : `USSE_RESP_SLVERR;
		end
		if (wr_cfg) begin
			d.baud_dbl = wd[`USSE_CFG_BAUD_DBL];
		end

		// ---- read channels
		ar_take = S_AXI_ARVALID && q.axi.arrdy;
		if (q.axi.rvalid && S_AXI_RREADY) begin
			d.axi.rvalid = 1'b0;
			d.axi.arrdy = 1'b1;
		end
		if (ar_take) begin
			d.axi.arrdy = 1'b0;
			d.axi.rvalid = 1'b1;
			d.axi.rresp = `USSE_RESP_OKAY;
			case (S_AXI_ARADDR)
				`USSE_ADDR_CTRL: d.axi.rdata = {24'h000000, q.ctrl};
				`USSE_ADDR_BUF: d.axi.rdata = {24'h000000, q.serial_buffer};
				`USSE_ADDR_CFG: d.axi.rdata = {31'h00000000, q.baud_dbl};
				`USSE_ADDR_STAT: d.axi.rdata = {30'h00000000, q.rx_st != RX_IDLE, q.tx_st != TX_IDLE};
				default: begin
					d.axi.rdata = 32'h00000000;
					d.axi.rresp = `USSE_RESP_SLVERR;
				end
			endcase
		end

		// ****************************************
		// transmitter
		// ****************************************
		if (btick) begin
			d.tx_div = 4'(q.tx_div + 4'h1);
		end
		case (q.tx_st)
			TX_IDLE: ;
			TX_WAIT: begin
				if (mode == MODE_SHIFT && mc_tick) begin
					d.tx_st = TX_SHIFT;
				end else if (mode == MODE_ASYNC8 && tx_roll) begin
					d.tx_st = TX_ALIGN;
				end
			end
			TX_ALIGN: begin
				if (mc_tick) begin
					d.tx_st = TX_START;
				end
			end
			TX_START: begin
				if (tx_roll) begin
					d.tx_st = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				tx_shift_ev = (mode == MODE_SHIFT) ? mc_tick : tx_roll;
				if (tx_shift_ev) begin
					d.tsr = {1'b0, q.tsr[8:1]};
					if (q.tsr[8:1] == `USSE_TX_END) begin
						d.tx_st = TX_IDLE;
						tx_set = 1'b1;
					end
				end
			end
			default: d.tx_st = TX_IDLE;
		endcase
		// a new write restarts the frame; nine-bit modes are not served here
		if (wr_buf && (mode == MODE_SHIFT || mode == MODE_ASYNC8)) begin
			d.tsr = {`USSE_TX_MARK, wd};
			d.tx_st = TX_WAIT;
		end

		// ****************************************
		// receiver
		// ****************************************
		if (btick) begin
			d.rx_div = 4'(q.rx_div + 4'h1);
		end
		case (q.rx_st)
			RX_IDLE: begin
				if (mode == MODE_SHIFT) begin
					if (q.ctrl[`USSE_CTRL_REN] && !q.ctrl[`USSE_CTRL_RXDONE] && q.tx_st == TX_IDLE && mc_tick) begin
						d.rsr = `USSE_RX0_INIT;
						d.rx_st = RX_SYNC;
					end
				end else if (mode == MODE_ASYNC8 && q.ctrl[`USSE_CTRL_REN] && btick) begin
					d.rx_prev = RXD_IN;
					if (q.rx_prev && !RXD_IN) begin
						d.rx_div = 4'h0;
						d.rsr = `USSE_RX1_INIT;
						vote_clr = 1'b1;
						d.rx_st = RX_START;
					end
				end
			end
			RX_SYNC: begin
				if (mc_phase == `USSE_SCK_SAMPLE) begin
					d.rx_prev = RXD_IN;
				end
				if (mc_tick) begin
					d.rsr = {1'b1, q.rsr[6:0], q.rx_prev};
					if (!q.rsr[7]) begin
						d.serial_buffer = usse_rev8({q.rsr[6:0], q.rx_prev});
						rx_set = 1'b1;
						d.rx_st = RX_IDLE;
					end
				end
			end
			RX_START: begin
				if (rx_decide) begin
					if (vote_bit) begin
						d.rx_st = RX_IDLE;
						d.rx_prev = 1'b0;
					end else begin
						d.rsr = {q.rsr[7:0], 1'b0};
						d.rx_st = RX_BITS;
					end
				end
			end
			RX_BITS: begin
				if (rx_decide) begin
					d.rsr = {q.rsr[7:0], vote_bit};
					if (!q.rsr[8]) begin
						if (!q.ctrl[`USSE_CTRL_RXDONE] && (!q.ctrl[`USSE_CTRL_MPC] || vote_bit)) begin
							d.serial_buffer = usse_rev8(q.rsr[7:0]);
							rx9_set = 1'b1;
							rx9_val = vote_bit;
							rx_set = 1'b1;
						end
						d.rx_prev = vote_bit;
						d.rx_st = RX_IDLE;
					end
				end
			end
			default: d.rx_st = RX_IDLE;
		endcase

		// ****************************************
		// control flags: hardware set beats a software clear
		// ****************************************
		if (wr_ctrl) begin
			d.ctrl = wd;
		end
		if (tx_set) begin
			d.ctrl[`USSE_CTRL_TXDONE] = 1'b1;
		end
		if (rx_set) begin
			d.ctrl[`USSE_CTRL_RXDONE] = 1'b1;
		end
		if (rx9_set) begin
			d.ctrl[`USSE_CTRL_RX9] = rx9_val;
		end

		// ****************************************
		// pins, taken from the next state
		// ****************************************
		sync_act = mode == MODE_SHIFT && (d.tx_st == TX_SHIFT || d.rx_st == RX_SYNC);
		if (mode == MODE_SHIFT) begin
			// shift clock low in the middle of each cycle, data sampled as it rises
			d.txd = !(sync_act && mc_phase >= `USSE_SCK_LO_FIRST && mc_phase <= `USSE_SCK_LO_LAST);
			d.rxd_oe = d.tx_st == TX_SHIFT;
			d.rxd_out = d.tsr[0];
		end else begin
			d.rxd_oe = 1'b0;
			d.rxd_out = 1'b1;
			case (d.tx_st)
				TX_START: d.txd = 1'b0;
				TX_SHIFT: d.txd = d.tsr[0];
				default: d.txd = 1'b1;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= '0;
			q.axi.awrdy <= 1'b1;
			q.axi.wrdy <= 1'b1;
			q.axi.arrdy <= 1'b1;
			q.ctrl <= `USSE_CTRL_RST;
			q.baud_dbl <= `USSE_CFG_RST;
			q.serial_buffer <= `USSE_BUF_RST;
			q.tx_st <= TX_IDLE;
			q.rx_st <= RX_IDLE;
			q.txd <= 1'b1;
			q.rxd_out <= 1'b1;
		end else if (CLK_EN) begin
			q <= d;
		end
	end

	assign S_AXI_AWREADY = q.axi.awrdy;
	assign S_AXI_WREADY = q.axi.wrdy;
	assign S_AXI_BVALID = q.axi.bvalid;
	assign S_AXI_BRESP = q.axi.bresp;
	assign S_AXI_ARREADY = q.axi.arrdy;
	assign S_AXI_RVALID = q.axi.rvalid;
	assign S_AXI_RDATA = q.axi.rdata;
	assign S_AXI_RRESP = q.axi.rresp;
	assign TXD_OUT = q.txd;
	assign RXD_OUT = q.rxd_out;
	assign RXD_OE = q.rxd_oe;
endmodule : usse_top

// ===== tb/usse_top_chk.sv
`timescale 1ns/10ps
`include "usse_cfg.svh"
module usse_chk import usse_pkg::*; #(
	parameter int MC_LEN = `USSE_MC_LEN
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// axi4-lite
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// serial pins
	input wire logic RXD_OUT,
	input wire logic RXD_OE,
	input wire logic TXD_OUT
);
	// ****************************************
	// helpers
	// ****************************************
	logic [7:0] oe_cnt_q;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) oe_cnt_q <= 8'h00;
		else if (RXD_OE) oe_cnt_q <= oe_cnt_q + 8'h01;
		else oe_cnt_q <= 8'h00;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// one shift clock: six cycles low, then high again
	sequence s_sck_low;
		!TXD_OUT [*6] ##1 TXD_OUT;
	endsequence
	// ****************************************
	// properties
	// ****************************************
	a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
		else $error("write response missing");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_ready_low: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write ready during response");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read data missing");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_unmapped_err: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h0c
		|=> S_AXI_RRESP == `USSE_RESP_SLVERR && S_AXI_RDATA == 32'h0)
		else $error("unmapped read not refused");
	a_sck_start: assert property ($rose(RXD_OE) |-> TXD_OUT ##[1:12] !TXD_OUT)
		else $error("shift clock absent");
	a_sck_pulse: assert property (RXD_OE && $fell(TXD_OUT) |-> s_sck_low)
		else $error("shift clock shape wrong");
	a_data_steady: assert property (RXD_OE && !TXD_OUT |-> $stable(RXD_OUT))
		else $error("data moved in low clock");
	a_send_span: assert property ($fell(RXD_OE) |-> oe_cnt_q == 8 * MC_LEN)
		else $error("send span wrong");
	c_send: cover property ($fell(RXD_OE));
endmodule : usse_chk

bind usse_top usse_chk #(.MC_LEN(MC_LEN)) chk_u (.MCLK, .RESET_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
	.RXD_OUT, .RXD_OE, .TXD_OUT);

// ===== tb/usse_peer.sv
`timescale 1ns/10ps
module usse_peer import usse_pkg::*; #(
	parameter int BIT_CYC = 64
) (
	// clock
	input wire logic clk,
	// device pins
	input wire logic txd,
	input wire logic dev_data,
	input wire logic dev_oe,
	input wire logic async_md,
	output logic line,
	// captured shift data
	output logic [7:0] got
);
	logic [7:0] sh = 8'h00;
	logic a_line = 1'b1;
	int fall_n = 0;
	initial got = 8'h00;
	// the device wins the pin while it drives it
	assign line = dev_oe ? dev_data : (async_md ? a_line : sh[0]);
	// ****************************************
	// shift register partner
	// ****************************************
	always @(posedge txd) begin
		if (dev_oe) got <= {dev_data, got[7:1]};
	end
	// bit 0 is shown before the first clock, so the first fall keeps it
	always @(negedge txd) begin
		if (fall_n > 0) sh <= {~sh[0], sh[7:1]};
		fall_n <= fall_n + 1;
	end
	task automatic load(input logic [7:0] b);
		sh <= b;
		fall_n <= 0;
		got <= 8'h00;
	endtask : load
	// ****************************************
	// asynchronous peer
	// ****************************************
	task automatic send(input logic [8:0] f);
		a_line <= 1'b0;
		repeat (BIT_CYC) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			a_line <= f[i];
			repeat (BIT_CYC) @(posedge clk);
		end
		a_line <= 1'b1;
		// a full idle bit, so the receiver sees the line high before the next start edge
		repeat (BIT_CYC) @(posedge clk);
	endtask : send
	task automatic glitch;
		a_line <= 1'b0;
		repeat (8) @(posedge clk);
		a_line <= 1'b1;
		repeat (100) @(posedge clk);
	endtask : glitch
	// start bit may be short, so sample well inside each later bit
	task automatic recv(input int bc, output logic [8:0] f, output logic ok);
		int n;
		n = 0;
		f = 9'h000;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		ok = (n < 4000);
		repeat (bc + bc / 2 - 6) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			f[i] = txd;
			repeat (bc) @(posedge clk);
		end
	endtask : recv
endmodule : usse_peer

// ===== tb/usse_top_tb.sv
`timescale 1ns/10ps
`include "usse_cfg.svh"
module usse_top_tb import usse_pkg::*; ;
	logic MCLK = 1'b0, RESET_N = 1'b0, CLK_EN = 1'b1, TIMER_OVF = 1'b0, async_md = 1'b0;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, pgot;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'h0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
	logic S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic RXD_OUT, RXD_OE, TXD_OUT, RXD_IN;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	int errors = 0, check_count = 0;
	usse_top dut_u (.MCLK, .RESET_N, .CLK_EN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
		.S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
		.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .TIMER_OVF, .RXD_IN, .RXD_OUT, .RXD_OE, .TXD_OUT);
	usse_peer peer_u (.clk(MCLK), .txd(TXD_OUT), .dev_data(RXD_OUT), .dev_oe(RXD_OE),
		.async_md(async_md), .line(RXD_IN), .got(pgot));
	initial forever #4 MCLK = ~MCLK;
	// overflow every second cycle: baud tick every fourth, bit time 64 cycles
	always @(posedge MCLK) TIMER_OVF <= ~TIMER_OVF;
	// ****************************************
	// tasks
	// ****************************************
	task automatic complete_run;
		if (errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	task automatic hang;
		$display("MISMATCH wait expected answer seen timeout");
		errors++;
		complete_run();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] s = 4'h1);
		int n;
		n = 0;
		@(posedge MCLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1 && n < 2000);
		S_AXI_BREADY <= 1'b0;
		if (n >= 2000) hang();
		chk($sformatf("bresp %h", a), er, S_AXI_BRESP);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge MCLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1 && n < 2000);
		S_AXI_RREADY <= 1'b0;
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		if (n >= 2000) hang();
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("rdata %h", a), e, d);
		chk($sformatf("rresp %h", a), `USSE_RESP_OKAY, r);
	endtask : rdc
	task automatic waitf(input int b);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		do begin
			rd(`USSE_ADDR_CTRL, d, r);
			n++;
		end while (d[b] !== 1'b1 && n < 400);
		if (n >= 400) hang();
	endtask : waitf
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		logic [8:0] f;
		logic ok;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		repeat (6) @(posedge MCLK);
		RESET_N <= 1'b1;
		rdc(`USSE_ADDR_CTRL, 32'h0);
		rdc(`USSE_ADDR_BUF, 32'h0);
		rdc(`USSE_ADDR_CFG, 32'h0);
		// a write without byte lane 0 leaves the register alone
		wr(`USSE_ADDR_CFG, 32'h1, `USSE_RESP_OKAY, 4'he);
		rdc(`USSE_ADDR_CFG, 32'h0);
		rd(8'h10, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", `USSE_RESP_SLVERR, r);
		wr(8'h10, 32'h5, `USSE_RESP_SLVERR);
		wr(`USSE_ADDR_STAT, 32'h3, `USSE_RESP_OKAY);
		rdc(`USSE_ADDR_STAT, 32'h0);
		// shift mode transmit
		wr(`USSE_ADDR_CTRL, 32'h0, `USSE_RESP_OKAY);
		peer_u.load(8'h00);
		wr(`USSE_ADDR_BUF, 32'ha5, `USSE_RESP_OKAY);
		waitf(`USSE_CTRL_TXDONE);
		chk("shift data", 32'ha5, pgot);
		chk("data drive", 32'h0, RXD_OE);
		rdc(`USSE_ADDR_CTRL, 32'h02);
		rdc(`USSE_ADDR_BUF, 32'h00);
		// shift mode receive
		peer_u.load(8'h6b);
		wr(`USSE_ADDR_CTRL, 32'h10, `USSE_RESP_OKAY);
		// freeze in the first low cycle of a shift clock: the pin must hold low
		n = 0;
		while (TXD_OUT !== 1'b1 && n < 200) begin
			@(posedge MCLK);
			n++;
		end
		while (TXD_OUT !== 1'b0 && n < 200) begin
			@(posedge MCLK);
			n++;
		end
		if (n >= 200) hang();
		CLK_EN <= 1'b0;
		repeat (30) @(posedge MCLK);
		chk("frozen shift clock", 32'h0, TXD_OUT);
		CLK_EN <= 1'b1;
		waitf(`USSE_CTRL_RXDONE);
		rdc(`USSE_ADDR_BUF, 32'h6b);
		rdc(`USSE_ADDR_CTRL, 32'h11);
		wr(`USSE_ADDR_CTRL, 32'h0, `USSE_RESP_OKAY);
		// asynchronous transmit
		async_md <= 1'b1;
		wr(`USSE_ADDR_CFG, 32'h1, `USSE_RESP_OKAY);
		rdc(`USSE_ADDR_CFG, 32'h1);
		wr(`USSE_ADDR_CTRL, 32'h40, `USSE_RESP_OKAY);
		fork
			peer_u.recv(64, f, ok);
			wr(`USSE_ADDR_BUF, 32'h96, `USSE_RESP_OKAY);
		join
		chk("frame seen", 32'h1, ok);
		chk("frame", 32'h196, f);
		waitf(`USSE_CTRL_TXDONE);
		rdc(`USSE_ADDR_CTRL, 32'h42);
		// baud double off: every fourth overflow ticks, bit time 128 cycles
		wr(`USSE_ADDR_CFG, 32'h0, `USSE_RESP_OKAY);
		wr(`USSE_ADDR_CTRL, 32'h40, `USSE_RESP_OKAY);
		fork
			peer_u.recv(128, f, ok);
			wr(`USSE_ADDR_BUF, 32'h3c, `USSE_RESP_OKAY);
		join
		chk("slow frame seen", 32'h1, ok);
		chk("slow frame", 32'h13c, f);
		waitf(`USSE_CTRL_TXDONE);
		wr(`USSE_ADDR_CFG, 32'h1, `USSE_RESP_OKAY);
		// asynchronous receive: false start, store, refusals
		wr(`USSE_ADDR_CTRL, 32'h50, `USSE_RESP_OKAY);
		peer_u.glitch();
		peer_u.send(9'h15a);
		waitf(`USSE_CTRL_RXDONE);
		rdc(`USSE_ADDR_BUF, 32'h5a);
		rdc(`USSE_ADDR_CTRL, 32'h55);
		peer_u.send(9'h177);
		rdc(`USSE_ADDR_BUF, 32'h5a);
		wr(`USSE_ADDR_CTRL, 32'h70, `USSE_RESP_OKAY);
		peer_u.send(9'h0c3);
		rdc(`USSE_ADDR_CTRL, 32'h70);
		peer_u.send(9'h13c);
		waitf(`USSE_CTRL_RXDONE);
		rdc(`USSE_ADDR_BUF, 32'h3c);
		rdc(`USSE_ADDR_CTRL, 32'h75);
		// nine-bit modes are not served: a buffer write starts nothing
		wr(`USSE_ADDR_CTRL, 32'h80, `USSE_RESP_OKAY);
		wr(`USSE_ADDR_BUF, 32'h11, `USSE_RESP_OKAY);
		rdc(`USSE_ADDR_STAT, 32'h0);
		rdc(`USSE_ADDR_CTRL, 32'h80);
		complete_run();
	end
endmodule : usse_top_tb
